// File: bench/secp_host.sv
// Serial host model that frames and clocks the EEPROM link
`timescale 1ns/1ns
module secp_host (
  input wire logic clk_sys,
  output logic cs_n,
  output logic sck,
  output logic si,
  input wire logic so,
  input wire logic so_oe
);
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic open_frame();
    cs_n <= 1'b0;
    tick(4);
  endtask
  // Eight clocks a bit gives the 800 ns serial clock; so is read late in the high phase
  task automatic byte_io(input logic [7:0] tx, output logic [7:0] rx, output logic oe);
    oe = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      si <= tx[i];
      tick(4);
      sck <= 1'b1;
      tick(4);
      // Released line reads inverted so a stale bit cannot pass
      rx[i] = so_oe ? so : ~so;
      oe = oe | so_oe;
      sck <= 1'b0;
    end
  endtask
  task automatic close_frame();
    tick(2);
    cs_n <= 1'b1;
    tick(6);
    si <= ~si;
  endtask
endmodule

// File: bench/secp_monitor.sv
// Pin-level checker for the serial EEPROM block
`timescale 1ns/1ns
module secp_monitor (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  input wire logic hold_n,
  input wire logic wp_n,
  input wire logic so,
  input wire logic so_oe
);
  // ==========================================
  // Output enable and framing
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  property p_idle_off;
    cs_n [*4] |-> !so_oe;
  endproperty
  a_idle_off: assert property (p_idle_off) else $error("so driven while deselected");
  property p_leave;
    $rose(cs_n) |-> ##[1:4] !so_oe;
  endproperty
  a_leave: assert property (p_leave) else $error("so not released after select");
  property p_start;
    $fell(cs_n) |-> !so_oe [*8];
  endproperty
  a_start: assert property (p_start) else $error("so driven during opcode");
  property p_hold_off;
    (!hold_n && !sck) [*5] |-> !so_oe;
  endproperty
  a_hold_off: assert property (p_hold_off) else $error("so driven while held");
  property p_oe_sel;
    $rose(so_oe) |-> !cs_n && hold_n;
  endproperty
  a_oe_sel: assert property (p_oe_sel) else $error("so enabled unselected");
  // ==========================================
  // Output timing
  // Sync delay moves the so update a few clocks past the pin fall
  property p_change_low;
    so_oe && $changed(so) |-> !$past(sck, 2);
  endproperty
  a_change_low: assert property (p_change_low) else $error("so moved in clock high");
  property p_bit_steady;
    so_oe && $changed(so) |=> $stable(so) [*6];
  endproperty
  a_bit_steady: assert property (p_bit_steady) else $error("so bit too short");
  property p_keep;
    so_oe ##1 (!cs_n && hold_n) [*4] |-> so_oe;
  endproperty
  a_keep: assert property (p_keep) else $error("output phase broken");
endmodule
bind secp_top secp_monitor mon (.clk_sys(clk_sys), .rstn(rstn), .cs_n(cs_n), .sck(sck),
  .si(si), .hold_n(hold_n), .wp_n(wp_n), .so(so), .so_oe(so_oe));

// File: bench/tb_top.sv
// Self-checking testbench of the serial EEPROM block
`timescale 1ns/1ns
module tb_top;
  import secp_pkg::*;
  logic clk_sys, rstn, hold_n, wp_n, cs_n, sck, si, so, so_oe, oe_any, oe;
  int fail_count, checked;
  logic [7:0] tx [6];
  logic [7:0] rx [6];
  secp_top #(.LARGE_PART(1'b1), .WRITE_CYCLES(600)) dut (.clk_sys(clk_sys), .rstn(rstn),
    .cs_n(cs_n), .sck(sck), .si(si), .hold_n(hold_n), .wp_n(wp_n), .so(so), .so_oe(so_oe));
  secp_host host (.clk_sys(clk_sys), .cs_n(cs_n), .sck(sck), .si(si), .so(so), .so_oe(so_oe));
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  // ==========================================
  // Shared tasks
  task automatic wrap_up();
    if (fail_count == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic frame(input int n);
    oe_any = 1'b0;
    host.open_frame();
    for (int k = 0; k < n; k++) begin
      host.byte_io(tx[k], rx[k], oe);
      oe_any = oe_any | oe;
    end
    host.close_frame();
  endtask
  task automatic op1(input logic [7:0] op);
    tx[0] = op;
    frame(1);
  endtask
  task automatic st(input logic [7:0] exp);
    tx[0] = 8'h05;
    tx[1] = 8'h00;
    frame(2);
    chk("status", exp, rx[1]);
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d0, d1, d2, input int nd);
    tx[0] = 8'h02;
    tx[1] = a[15:8];
    tx[2] = a[7:0];
    tx[3] = d0;
    tx[4] = d1;
    tx[5] = d2;
    frame(3 + nd);
  endtask
  task automatic rd2(input logic [15:0] a, input logic [7:0] e0, e1);
    tx[0] = 8'h03;
    tx[1] = a[15:8];
    tx[2] = a[7:0];
    frame(5);
    chk("read0", e0, rx[3]);
    chk("read1", e1, rx[4]);
  endtask
  task automatic sw(input logic [7:0] v);
    tx[0] = 8'h01;
    tx[1] = v;
    frame(2);
  endtask
  task automatic wait_ready();
    for (int t = 0; t < 20; t++) begin
      tx[0] = 8'h05;
      frame(2);
      if (rx[1][0] === 1'b0) return;
    end
    chk("ready_timeout", 8'h00, rx[1]);
    wrap_up();
  endtask
  // ==========================================
  // Scenarios
  task automatic s_latch();
    st(8'h00);
    op1(8'h06);
    st(8'h02);
    wp_n <= 1'b0;
    op1(8'h0C);
    st(8'h00);
    wp_n <= 1'b1;
    op1(8'h0E);
    st(8'h02);
    op1(8'h04);
    st(8'h00);
  endtask
  task automatic s_page();
    op1(8'h06);
    wr(16'hFFFF, 8'hA1, 8'hB2, 8'hC3, 3);
    op1(8'h06);
    st(STAT_BUSY);
    tx[0] = 8'h03;
    frame(3);
    chk("busy_oe", 8'h00, {7'h00, oe_any});
    wait_ready();
    st(8'h00);
    op1(8'h06);
    wr(16'h0000, 8'hD4, 8'h00, 8'h00, 1);
    wait_ready();
    rd2(16'hFFFF, 8'hA1, 8'hD4);
    rd2(16'h1FE0, 8'hB2, 8'hC3);
    wr(16'h1FFF, 8'h55, 8'h00, 8'h00, 1);
    st(8'h00);
    rd2(16'h1FFF, 8'hA1, 8'hD4);
  endtask
  task automatic s_protect();
    op1(8'h06);
    sw(8'hFF);
    wait_ready();
    st(8'h8C);
    op1(8'h06);
    wr(16'h0000, 8'hEE, 8'h00, 8'h00, 1);
    wait_ready();
    rd2(16'h1FFF, 8'hA1, 8'hD4);
    wp_n <= 1'b0;
    op1(8'h06);
    sw(8'h00);
    st(8'h8E);
    wp_n <= 1'b1;
    sw(8'h00);
    wait_ready();
    st(8'h00);
    sw(8'h0C);
    st(8'h00);
  endtask
  task automatic s_bad();
    tx[0] = 8'h07;
    tx[1] = 8'h05;
    tx[2] = 8'h06;
    frame(3);
    chk("bad_oe", 8'h00, {7'h00, oe_any});
    st(8'h00);
    tx[0] = 8'h16;
    frame(1);
    st(8'h00);
  endtask
  task automatic s_hold();
    op1(8'h06);
    host.open_frame();
    host.byte_io(8'h05, rx[0], oe);
    hold_n <= 1'b0;
    host.tick(4);
    // Clock keeps toggling while held; none of it may count
    host.byte_io(8'hFF, rx[2], oe);
    chk("held_oe", 8'h00, {7'h00, oe});
    hold_n <= 1'b1;
    host.tick(4);
    host.byte_io(8'h00, rx[1], oe);
    host.close_frame();
    chk("resumed", 8'h02, rx[1]);
    chk("resumed_oe", 8'h01, {7'h00, oe});
  endtask
  initial begin
    rstn = 1'b0;
    hold_n = 1'b1;
    wp_n = 1'b1;
    fail_count = 0;
    checked = 0;
    repeat (8) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (8) @(posedge clk_sys);
    s_latch();
    s_page();
    s_protect();
    s_bad();
    s_hold();
    wrap_up();
  end
endmodule

// File: rtl/secp_pkg.sv
// Constants, types and encodings of the serial EEPROM command and protect block
//
// Behaviour
// - Frames open on chip select falling; opcode byte first, everything MSB first.
// - Opcode 0000x110 sets the write latch, 0000x100 clears it.
// - Opcode 0000x101 reads the status byte, 0000x001 writes it.
// - Opcode 0000x011 reads the array, 0000x010 writes it.
// - Write latch is clear after power-up; host sets it before programming.
// - Clear-latch instruction disables programming regardless of the protect pin.
// - Status: bit0 busy, bit1 latch, bits3:2 protect level, bit7 pin-protect enable.
// - Bits 6:4 read zero when idle; whole byte reads ones while busy.
// - Small part: levels protect none, 0C00-0FFF, 0800-0FFF, 0000-0FFF.
// - Large part: levels protect 1800-1FFF, 1000-1FFF, 0000-1FFF; writes there dropped.
// - Protect and enable bits change only with latch set and a timed cycle.
// - Pin low plus enable bit set rejects every status write.
// - Enable bit cannot be cleared while pin protection holds.
// - Latch clear blocks all writes; latch set allows unprotected blocks and status.
// - Array read takes opcode, 16-bit address, then ignores input; upper bits ignored.
// - Read address increments per byte and wraps from top to zero.
// - While busy, only the status read is obeyed.
// - Write cycle starts only if select rises right after a byte's last bit.
// - Page write: low five address bits wrap, upper bits stay fixed.
// - Completion of any write cycle clears the write latch.
// - Write without latch is discarded; device waits for next select fall.
// - Unknown opcode: input ignored, output off until select falls again.
// - Select high: input ignored, output off.
// - Hold low while clock low pauses the frame and turns output off.
package secp_pkg;
  localparam logic [3:0] OPC_HI_ZERO = 4'h0;
  localparam logic [2:0] OPC_SET_LATCH = 3'h6;
  localparam logic [2:0] OPC_CLR_LATCH = 3'h4;
  localparam logic [2:0] OPC_STAT_RD = 3'h5;
  localparam logic [2:0] OPC_STAT_WR = 3'h1;
  localparam logic [2:0] OPC_ARR_RD = 3'h3;
  localparam logic [2:0] OPC_ARR_WR = 3'h2;
  localparam int ADDR_W = 13;
  localparam int PAGE_BYTES = 32;
  localparam int PAGE_W = 5;
  localparam int FIFO_DEPTH = 16;
  localparam logic [7:0] STAT_BUSY = 8'hFF;
  localparam int ST_PIN_PROT = 7;
  localparam int ST_BP_HI = 3;
  localparam int ST_BP_LO = 2;
  localparam logic [3:0] ADDR_LAST_BIT = 4'hF;
  localparam logic [2:0] BYTE_LAST_BIT = 3'h7;
  localparam logic [1:0] BP_NONE = 2'h0;
  localparam logic [1:0] BP_QUARTER = 2'h1;
  localparam logic [1:0] BP_HALF = 2'h2;
  localparam logic [4:0] PIN_IDLE = 5'h13;
  localparam int WRITE_TIME_MS = 5;
  localparam int CLK_HZ = 10000000;
  localparam int WRITE_CYCLES_DEF = WRITE_TIME_MS * (CLK_HZ / 1000);
  typedef enum logic [2:0] {
    SECP_IDLE, SECP_OPC, SECP_ADDR, SECP_RDATA, SECP_WDATA, SECP_SRD, SECP_SRW, SECP_DEAD
  } secp_state_t;
endpackage

// File: rtl/secp_top.sv
// Serial EEPROM slave: pin sampling, command decode, protection, page FIFO and array
`timescale 1ns/1ns

// ==========================================================
// Byte FIFO between serial receive and page buffer
module secp_fifo #(
  parameter int WIDTH = 13,
  parameter int DEPTH = 16
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);
  typedef struct packed {
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [PW:0] cnt;
  } secp_fifo_regs_t;
  secp_fifo_regs_t f;
  secp_fifo_regs_t next_f;
  logic [WIDTH-1:0] mem [0:DEPTH-1];
  logic push;
  logic pop;
  assign in_ready = (f.cnt != (PW+1)'(DEPTH));
  assign out_valid = (f.cnt != '0);
  assign out_data = mem[f.rp];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  always_comb begin
    next_f = f;
    if (push) begin
      next_f.wp = (f.wp == PW'(DEPTH - 1)) ? '0 : f.wp + 1'b1;
    end
    if (pop) begin
      next_f.rp = (f.rp == PW'(DEPTH - 1)) ? '0 : f.rp + 1'b1;
    end
    next_f.cnt = f.cnt + (PW+1)'(push) - (PW+1)'(pop);
  end
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[f.wp] <= in_data;
    end
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      f <= '0;
    end else begin
      f <= next_f;
    end
  end
endmodule

// ==========================================================
// Top level
module secp_top import secp_pkg::*; #(
  parameter bit LARGE_PART = 1'b1,
  parameter int WRITE_CYCLES = WRITE_CYCLES_DEF
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  input wire logic hold_n,
  input wire logic wp_n,
  output logic so,
  output logic so_oe
);
  localparam int AW = LARGE_PART ? ADDR_W : ADDR_W - 1;
  localparam logic [ADDR_W-1:0] AMASK = ADDR_W'((1 << AW) - 1);
  localparam int FW = PAGE_W + 8;

  typedef struct packed {
    logic [4:0] s1;
    logic [4:0] s2;
    logic sck_d;
    logic cs_d;
    logic held;
    secp_state_t st;
    logic [3:0] bitcnt;
    logic [7:0] sh;
    logic [15:0] ash;
    logic [7:0] osh;
    logic so;
    logic [ADDR_W-1:0] addr;
    logic rd;
    logic got;
    logic [7:0] srv;
    logic wel;
    logic [1:0] bp;
    logic pin_protect_enable;
    logic busy;
    logic kind_stat;
    logic [15:0] wcnt;
    logic [PAGE_W:0] idx;
    logic [PAGE_BYTES-1:0] pvalid;
  } secp_regs_t;

  secp_regs_t r;
  secp_regs_t next_r;
  logic rst_s1;
  logic rst_n;
  logic [7:0] arr [0:(1 << ADDR_W)-1];
  logic [7:0] page [0:PAGE_BYTES-1];
  logic arr_we;
  logic [ADDR_W-1:0] arr_wa;
  logic [7:0] arr_wd;
  logic f_in_valid;
  logic f_in_ready;
  logic [FW-1:0] f_in_data;
  logic f_out_valid;
  logic f_out_ready;
  logic [FW-1:0] f_out_data;
  logic cs_s;
  logic sck_s;
  logic si_s;
  logic hold_s;
  logic wp_s;
  logic hw_prot;
  logic [7:0] status;
  logic [ADDR_W-1:0] copy_a;

  // ==========================================================
  // Reset release
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rst_s1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n <= rst_s1;
    end
  end

  // Protected-range test on the decoded part size
  function automatic logic is_prot(input logic [ADDR_W-1:0] a, input logic [1:0] lvl);
    logic top;
    logic sub;
    top = a[AW-1];
    sub = a[AW-2];
    unique case (lvl)
      BP_NONE: is_prot = 1'b0;
      BP_QUARTER: is_prot = top & sub;
      BP_HALF: is_prot = top;
      default: is_prot = 1'b1;
    endcase
  endfunction

  assign cs_s = r.s2[4];
  assign sck_s = r.s2[3];
  assign si_s = r.s2[2];
  assign hold_s = r.s2[1];
  assign wp_s = r.s2[0];
  assign hw_prot = !wp_s & r.pin_protect_enable;
  assign status = r.busy ? STAT_BUSY : {r.pin_protect_enable, 3'h0, r.bp, r.wel, 1'b0};
  assign copy_a = {r.addr[ADDR_W-1:PAGE_W], r.idx[PAGE_W-1:0]};
  assign so = r.so;
  // Output only in an output phase, selected and not held
  assign so_oe = !cs_s & !r.held & ((r.st == SECP_RDATA) | (r.st == SECP_SRD));
  // Page buffer is frozen while the copy into the array runs
  assign f_out_ready = !(r.busy & !r.kind_stat & (r.idx != '0));

  secp_fifo #(.WIDTH(FW), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .in_valid(f_in_valid),
    .in_ready(f_in_ready),
    .in_data(f_in_data),
    .out_valid(f_out_valid),
    .out_ready(f_out_ready),
    .out_data(f_out_data)
  );

  // ==========================================================
  // Next-state logic
  always_comb begin
    logic rise;
    logic fall;
    logic bdone;
    logic [7:0] nsh;
    logic [ADDR_W-1:0] a;
    rise = 1'b0;
    fall = 1'b0;
    bdone = 1'b0;
    nsh = 8'h00;
    a = '0;
    next_r = r;
    arr_we = 1'b0;
    arr_wa = copy_a;
    arr_wd = page[r.idx[PAGE_W-1:0]];
    f_in_valid = 1'b0;
    f_in_data = {r.addr[PAGE_W-1:0], r.sh};
    next_r.s1 = {cs_n, sck, si, hold_n, wp_n};
    next_r.s2 = r.s1;
    next_r.sck_d = sck_s;
    next_r.cs_d = cs_s;
    if (!sck_s) begin
      next_r.held = !hold_s;
    end
    rise = sck_s & !r.sck_d & !r.held & !cs_s;
    fall = !sck_s & r.sck_d & !r.held & !cs_s;
    if (f_out_valid & f_out_ready) begin
      next_r.pvalid[f_out_data[FW-1:8]] = 1'b1;
    end
    if (cs_s) begin
      next_r.st = SECP_IDLE;
      next_r.bitcnt = '0;
      if (!r.cs_d) begin
        // Commit only on a byte boundary, checked at the select edge
        if (r.st == SECP_WDATA && r.got && r.bitcnt == '0) begin
          next_r.busy = 1'b1;
          next_r.kind_stat = 1'b0;
          next_r.wcnt = '0;
          next_r.idx = '0;
        end
        if (r.st == SECP_SRW && r.got && r.bitcnt == '0 && !hw_prot) begin
          next_r.busy = 1'b1;
          next_r.kind_stat = 1'b1;
          next_r.wcnt = '0;
          next_r.idx = '0;
        end
      end
    end else if (r.st == SECP_IDLE) begin
      next_r.st = SECP_OPC;
    end else if (rise) begin
      nsh = {r.sh[6:0], si_s};
      next_r.sh = nsh;
      next_r.ash = {r.ash[14:0], si_s};
      bdone = (r.bitcnt[2:0] == BYTE_LAST_BIT);
      next_r.bitcnt = bdone ? 4'h0 : r.bitcnt + 4'h1;
      unique case (r.st)
        SECP_OPC: begin
          if (bdone) begin
            next_r.st = SECP_DEAD;
            next_r.got = 1'b0;
            if (nsh[7:4] != OPC_HI_ZERO) begin
              next_r.st = SECP_DEAD;
            end else if (r.busy) begin
              if (nsh[2:0] == OPC_STAT_RD) begin
                next_r.osh = status;
                next_r.st = SECP_SRD;
              end
            end else begin
              unique case (nsh[2:0])
                OPC_SET_LATCH: next_r.wel = 1'b1;
                OPC_CLR_LATCH: next_r.wel = 1'b0;
                OPC_STAT_RD: begin
                  next_r.osh = status;
                  next_r.st = SECP_SRD;
                end
                OPC_STAT_WR: begin
                  if (r.wel) begin
                    next_r.st = SECP_SRW;
                  end
                end
                OPC_ARR_RD: begin
                  next_r.rd = 1'b1;
                  next_r.st = SECP_ADDR;
                end
                OPC_ARR_WR: begin
                  if (r.wel) begin
                    next_r.rd = 1'b0;
                    next_r.pvalid = '0;
                    next_r.st = SECP_ADDR;
                  end
                end
                default: next_r.st = SECP_DEAD;
              endcase
            end
          end
        end
        SECP_ADDR: begin
          next_r.bitcnt = r.bitcnt + 4'h1;
          if (r.bitcnt == ADDR_LAST_BIT) begin
            a = next_r.ash[ADDR_W-1:0] & AMASK;
            next_r.bitcnt = '0;
            if (r.rd) begin
              next_r.osh = arr[a];
              next_r.addr = (a + 1'b1) & AMASK;
              next_r.st = SECP_RDATA;
            end else begin
              next_r.addr = a;
              next_r.st = SECP_WDATA;
            end
          end
        end
        SECP_RDATA: begin
          if (bdone) begin
            next_r.osh = arr[r.addr];
            next_r.addr = (r.addr + 1'b1) & AMASK;
          end
        end
        SECP_SRD: begin
          if (bdone) begin
            next_r.osh = status;
          end
        end
        SECP_WDATA: begin
          if (bdone && f_in_ready) begin
            f_in_valid = 1'b1;
            f_in_data = {r.addr[PAGE_W-1:0], nsh};
            next_r.addr[PAGE_W-1:0] = r.addr[PAGE_W-1:0] + 1'b1;
            next_r.got = 1'b1;
          end
        end
        SECP_SRW: begin
          if (bdone) begin
            next_r.srv = nsh;
            next_r.got = 1'b1;
          end
        end
        SECP_IDLE, SECP_DEAD: begin
        end
      endcase
    end else if (fall && (r.st == SECP_RDATA || r.st == SECP_SRD)) begin
      next_r.so = r.osh[7];
      next_r.osh = {r.osh[6:0], 1'b0};
    end
    // Timed write cycle; page copy waits until the FIFO has drained
    if (r.busy) begin
      next_r.wcnt = r.wcnt + 16'h1;
      if (!r.kind_stat && r.idx != (PAGE_W+1)'(PAGE_BYTES)) begin
        if (!f_out_valid || r.idx != '0) begin
          next_r.idx = r.idx + 1'b1;
          arr_we = r.pvalid[r.idx[PAGE_W-1:0]] & !is_prot(copy_a, r.bp);
        end
      end
      if (r.wcnt >= 16'(WRITE_CYCLES - 1)) begin
        next_r.busy = 1'b0;
        next_r.wel = 1'b0;
        if (r.kind_stat) begin
          next_r.bp = r.srv[ST_BP_HI:ST_BP_LO];
          next_r.pin_protect_enable = r.srv[ST_PIN_PROT];
        end
      end
    end
  end

  // ==========================================================
  // Storage
  always_ff @(posedge clk_sys) begin
    if (arr_we) begin
      arr[arr_wa] <= arr_wd;
    end
    if (f_out_valid & f_out_ready) begin
      page[f_out_data[FW-1:8]] <= f_out_data[7:0];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      // Edge detectors start at pin idle so no false edge follows reset
      r <= '{s1: PIN_IDLE, s2: PIN_IDLE, cs_d: 1'b1, st: SECP_IDLE, wel: 1'b0, default: '0};
    end else begin
      r <= next_r;
    end
  end
endmodule
